// >>> inc/hfd_pkg.sv
/*
  Shared constants and state types for the DDR flash bus pin block.
  Assumes a 25 MHz reference clock and an 8-bit DDR link clocked by the host.
*/
package hfd_pkg;
  // Reference clock period and bus geometry.
  localparam int REF_PERIOD_NS = 40;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int CA_W = 48;
  localparam int CA_WORDS = 3;
  localparam int CA_RW_BIT = 47;
  localparam int LAT_W = 4;
  localparam int EXT_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam logic [1:0] CA_CNT_LAST = 2'h2;
  localparam logic [LAT_W-1:0] LAT_LAST = 4'h1;

  // Link state, Gray coded along command, latency, read.
  typedef enum logic [1:0] {
    LK_CA = 2'b00,
    LK_LAT = 2'b01,
    LK_RD = 2'b11,
    LK_WR = 2'b10
  } hfd_link_e;

  // Device-level state seen by the user.
  typedef enum logic [1:0] {
    DV_POR = 2'b00,
    DV_STANDBY = 2'b01,
    DV_ARRAY_RD = 2'b11,
    DV_HWRST = 2'b10
  } hfd_dev_e;

  // Power-on reset sequencer state.
  typedef enum logic [1:0] {
    PS_RUN = 2'b00,
    PS_EXT = 2'b01,
    PS_DONE = 2'b11
  } hfd_por_e;
endpackage

// >>> inc/hfd_stream_if.sv
/*
  Valid/ready word stream between the block's own modules.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface hfd_stream_if #(parameter int WIDTH = 16);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface

// >>> design/hfd_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock; the reader may stall so that the FIFO really fills.
*/
`timescale 1ns/1ps
module hfd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Streams.
  hfd_stream_if.snk in_s,
  hfd_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////
  // Full and empty come from the count, so both are exact every cycle.
  assign in_s.ready = (count_reg < (AW+1)'(DEPTH));
  assign out_s.valid = (count_reg != '0);
  assign out_s.data = mem[rd_ptr_reg];
  assign push = in_s.valid & in_s.ready;
  assign pop = out_s.valid & out_s.ready;

  // Storage is written without reset; only the pointers and the count need a value.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_s.data;
    end
  end

  // Pointers wrap on the depth, which is expected to be a power of two.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> design/hfd_por_seq.sv
/*
  Power-on reset sequencer driving the open-drain reset output.
  Assumes rst_i marks the internal power-on event and ext_cycles_i is static.
*/
`timescale 1ns/1ps
module hfd_por_seq
  import hfd_pkg::*;
#(
  parameter int POR_CYCLES = 5000,
  parameter int CNT_W = 24
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // User-configured extra low period, in reference clock cycles.
  input wire logic [hfd_pkg::EXT_W-1:0] ext_cycles_i,
  // Reset output hold and standby entry.
  output logic por_hold_o,
  output logic standby_o
);
  hfd_por_e state_reg;
  logic [CNT_W-1:0] cnt_reg;

  ////////////////////////////////////////////////////////////////////////
  // Internal reset first, then the user extension, then release.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= PS_RUN;
      cnt_reg <= '0;
      por_hold_o <= 1'b1;
      standby_o <= 1'b0;
    end else begin
      standby_o <= 1'b0;
      unique case (state_reg)
        PS_RUN: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(POR_CYCLES - 1)) begin
            cnt_reg <= '0;
            state_reg <= PS_EXT;
          end
        end
        PS_EXT: begin
          if (cnt_reg >= CNT_W'(ext_cycles_i)) begin
            state_reg <= PS_DONE;
            por_hold_o <= 1'b0;
            standby_o <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        PS_DONE: begin
          por_hold_o <= 1'b0;
        end
        default: begin
          state_reg <= PS_RUN;
        end
      endcase
    end
  end
endmodule

// >>> design/hfd_pin_top.sv
/*
  Device side of an 8-bit DDR source-synchronous flash bus: pin logic.
  Assumes the host clocks the link on ck_i only inside frames, keeps chip
  select changes to the low phase of the clock, and that the differential
  pair is resolved to ck_i by the pads. User logic runs on ref_clk_i.
*/
`timescale 1ns/1ps
module hfd_pin_top
  import hfd_pkg::*;
#(
  parameter int POR_TIME_NS = 200000,
  parameter int POR_CYCLES = (POR_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS,
  parameter int WR_DEPTH = FIFO_DEPTH
) (
  // Reference clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Link clocks and chip select.
  input wire logic ck_i,
  input wire logic skew_clock_i,
  input wire logic cs_n_i,
  // Data lines and read strobe.
  input wire logic [hfd_pkg::BYTE_W-1:0] dq_i,
  output logic [hfd_pkg::BYTE_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic read_strobe_o,
  output logic read_strobe_oe_o,
  // Hardware reset pin and open-drain outputs.
  input wire logic reset_n_i,
  output logic int_n_o,
  output logic int_n_oe_o,
  output logic por_out_n_o,
  output logic por_out_n_oe_o,
  // User configuration and events.
  input wire logic skew_en_i,
  input wire logic [hfd_pkg::LAT_W-1:0] latency_i,
  input wire logic [hfd_pkg::EXT_W-1:0] por_ext_i,
  input wire logic event_i,
  input wire logic int_clear_i,
  // Decoded command/address.
  output logic [hfd_pkg::CA_W-1:0] ca_o,
  output logic ca_valid_o,
  // Read words from the user.
  input wire logic [hfd_pkg::WORD_W-1:0] rd_data_i,
  input wire logic rd_valid_i,
  output logic rd_ready_o,
  // Write words to the user.
  output logic [hfd_pkg::WORD_W-1:0] wr_data_o,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  // Status.
  output hfd_pkg::hfd_dev_e dev_state_o,
  output logic overrun_o
);
  import hfd_pkg::*;

  // Reference-domain state.
  logic rstn_s1_reg;
  logic rstn_s2_reg;
  logic hw_rst_reg;
  logic core_rst;
  logic ca_s1_reg;
  logic ca_s2_reg;
  logic ca_s3_reg;
  logic wr_s1_reg;
  logic wr_s2_reg;
  logic wr_s3_reg;
  logic ack_s1_reg;
  logic ack_s2_reg;
  logic rd_req_reg;
  logic [WORD_W-1:0] rd_hold_reg;
  logic pend_reg;
  logic [WORD_W-1:0] pend_data_reg;
  logic int_flag_reg;
  logic overrun_evt;
  logic wr_new;
  logic rd_accept;
  logic por_hold;
  logic standby;
  // Link-domain state.
  logic frame_rst;
  logic link_rst;
  hfd_link_e state_reg;
  logic [1:0] ca_cnt_reg;
  logic [CA_W-1:0] ca_reg;
  logic [CA_W-1:0] ca_word_reg;
  logic ca_tgl_reg;
  logic [LAT_W-1:0] lat_cnt_reg;
  logic [BYTE_W-1:0] hi_byte_reg;
  logic [BYTE_W-1:0] dq_hi_reg;
  logic [BYTE_W-1:0] dq_lo_reg;
  logic rd_oe_reg;
  logic [WORD_W-1:0] rd_word_reg;
  logic rd_full_reg;
  logic rd_req_s1_reg;
  logic rd_req_s2_reg;
  logic rd_ack_reg;
  logic rd_take;
  logic [WORD_W-1:0] wr_word_reg;
  logic wr_tgl_reg;
  logic skew_s1_reg;
  logic skew_s2_reg;
  logic [LAT_W-1:0] lat_s1_reg;
  logic [LAT_W-1:0] lat_s2_reg;
  logic [WORD_W-1:0] word;
  logic [CA_W-1:0] ca_full;

  hfd_stream_if #(.WIDTH(WORD_W)) fifo_in ();
  hfd_stream_if #(.WIDTH(WORD_W)) fifo_out ();

  ////////////////////////////////////////////////////////////////////////
  // Hardware reset pin. Syncs reset to one, like the pin's pull-up.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rstn_s1_reg <= 1'b1;
      rstn_s2_reg <= 1'b1;
      hw_rst_reg <= 1'b0;
    end else begin
      rstn_s1_reg <= reset_n_i;
      rstn_s2_reg <= rstn_s1_reg;
      hw_rst_reg <= ~rstn_s2_reg;
    end
  end

  // Both resets are flop or pin driven, so the OR cannot glitch from logic.
  assign core_rst = rst_i | hw_rst_reg;
  assign link_rst = core_rst;
  // Chip select high holds the frame logic cleared; no clock edge is needed.
  assign frame_rst = core_rst | cs_n_i;

  // Device state: hardware reset returns to array read, release to standby.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dev_state_o <= DV_POR;
    end else if (hw_rst_reg) begin
      dev_state_o <= DV_HWRST;
    end else if (dev_state_o == DV_HWRST) begin
      dev_state_o <= DV_ARRAY_RD;
    end else if (standby) begin
      dev_state_o <= DV_STANDBY;
    end
  end

  // Power-on reset sequencing for the open-drain reset output.
  hfd_por_seq #(
    .POR_CYCLES(POR_CYCLES)
  ) u_por (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ext_cycles_i(por_ext_i),
    .por_hold_o(por_hold),
    .standby_o(standby)
  );

  // Open drain: the drive value is always low, only the enable moves.
  assign por_out_n_o = 1'b0;
  assign por_out_n_oe_o = por_hold;
  assign int_n_o = 1'b0;
  assign int_n_oe_o = int_flag_reg;

  ////////////////////////////////////////////////////////////////////////
  // Link configuration. Latency is a bus, so change it only between frames.
  always_ff @(posedge ck_i or posedge link_rst) begin
    if (link_rst) begin
      skew_s1_reg <= 1'b0;
      skew_s2_reg <= 1'b0;
      lat_s1_reg <= '0;
      lat_s2_reg <= '0;
    end else begin
      skew_s1_reg <= skew_en_i;
      skew_s2_reg <= skew_s1_reg;
      lat_s1_reg <= latency_i;
      lat_s2_reg <= lat_s1_reg;
    end
  end

  // Rising edge: take the high byte in, launch the high read byte out.
  always_ff @(posedge ck_i or posedge frame_rst) begin
    if (frame_rst) begin
      hi_byte_reg <= '0;
      dq_hi_reg <= '0;
    end else begin
      hi_byte_reg <= dq_i;
      if (rd_oe_reg) begin
        dq_hi_reg <= rd_word_reg[WORD_W-1:BYTE_W];
      end
    end
  end

  // A word is complete at each falling edge.
  assign word = {hi_byte_reg, dq_i};
  assign ca_full = {ca_reg[CA_W-WORD_W-1:0], word};

  // Frame state machine, on the falling edge where each word completes.
  always_ff @(negedge ck_i or posedge frame_rst) begin
    if (frame_rst) begin
      state_reg <= LK_CA;
      ca_cnt_reg <= '0;
      ca_reg <= '0;
      lat_cnt_reg <= '0;
      rd_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        LK_CA: begin
          ca_reg <= ca_full;
          ca_cnt_reg <= ca_cnt_reg + 1'b1;
          if (ca_cnt_reg == CA_CNT_LAST) begin
            if (ca_full[CA_RW_BIT]) begin
              state_reg <= LK_LAT;
              lat_cnt_reg <= lat_s2_reg;
            end else begin
              state_reg <= LK_WR;
            end
          end
        end
        LK_LAT: begin
          lat_cnt_reg <= lat_cnt_reg - 1'b1;
          if (lat_cnt_reg <= LAT_LAST) begin
            state_reg <= LK_RD;
            rd_oe_reg <= 1'b1;
          end
        end
        LK_RD: begin
          rd_oe_reg <= 1'b1;
        end
        LK_WR: begin
          rd_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Event toggles survive frames so that the far side stays in step.
  always_ff @(negedge ck_i or posedge link_rst) begin
    if (link_rst) begin
      ca_tgl_reg <= 1'b0;
      ca_word_reg <= '0;
      wr_tgl_reg <= 1'b0;
      wr_word_reg <= '0;
    end else begin
      if (!frame_rst && state_reg == LK_CA && ca_cnt_reg == CA_CNT_LAST) begin
        ca_word_reg <= ca_full;
        ca_tgl_reg <= ~ca_tgl_reg;
      end
      if (!frame_rst && state_reg == LK_WR) begin
        wr_word_reg <= word;
        wr_tgl_reg <= ~wr_tgl_reg;
      end
    end
  end

  // Read word handshake, receiving end: request toggle through two flops.
  always_ff @(negedge ck_i or posedge link_rst) begin
    if (link_rst) begin
      rd_req_s1_reg <= 1'b0;
      rd_req_s2_reg <= 1'b0;
      rd_ack_reg <= 1'b0;
    end else begin
      rd_req_s1_reg <= rd_req_reg;
      rd_req_s2_reg <= rd_req_s1_reg;
      if (rd_take) begin
        rd_ack_reg <= ~rd_ack_reg;
      end
    end
  end

  // A word is taken when the holder is free or being emptied this edge.
  assign rd_take = (rd_req_s2_reg != rd_ack_reg) &&
                   (!rd_full_reg || state_reg == LK_RD) && !frame_rst;

  // Falling edge: launch the low byte and refill the word holder.
  always_ff @(negedge ck_i or posedge frame_rst) begin
    if (frame_rst) begin
      rd_word_reg <= '0;
      rd_full_reg <= 1'b0;
      dq_lo_reg <= '0;
    end else begin
      if (state_reg == LK_RD) begin
        dq_lo_reg <= rd_word_reg[BYTE_W-1:0];
      end
      if (rd_take) begin
        rd_word_reg <= rd_hold_reg;
        rd_full_reg <= 1'b1;
      end else if (state_reg == LK_RD) begin
        rd_full_reg <= 1'b0;
      end
    end
  end

  // DDR output: the clock selects which launched byte sits on the lines,
  // so data changes on each ck_i edge, which the strobe follows only while the skew clock is off.
  assign dq_o = ck_i ? dq_hi_reg : dq_lo_reg;
  assign dq_oe_o = rd_oe_reg;
  // The strobe is a gated copy of the selected clock; the skew clock only
  // matters during reads, so writes do not need it running.
  assign read_strobe_o = rd_oe_reg & (skew_s2_reg ? skew_clock_i : ck_i);
  assign read_strobe_oe_o = rd_oe_reg;

  ////////////////////////////////////////////////////////////////////////
  // Event syncs into the reference domain; stages two and three feed the detect, stage one never does.
  always_ff @(posedge ref_clk_i or posedge core_rst) begin
    if (core_rst) begin
      ca_s1_reg <= 1'b0;
      ca_s2_reg <= 1'b0;
      ca_s3_reg <= 1'b0;
      wr_s1_reg <= 1'b0;
      wr_s2_reg <= 1'b0;
      wr_s3_reg <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      ca_s1_reg <= ca_tgl_reg;
      ca_s2_reg <= ca_s1_reg;
      ca_s3_reg <= ca_s2_reg;
      wr_s1_reg <= wr_tgl_reg;
      wr_s2_reg <= wr_s1_reg;
      wr_s3_reg <= wr_s2_reg;
      ack_s1_reg <= rd_ack_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  // Command/address hand-off; the word changes on the toggle's edge and is stable long before the synced toggle.
  always_ff @(posedge ref_clk_i or posedge core_rst) begin
    if (core_rst) begin
      ca_o <= '0;
      ca_valid_o <= 1'b0;
    end else begin
      ca_valid_o <= ca_s2_reg ^ ca_s3_reg;
      if (ca_s2_reg ^ ca_s3_reg) begin
        ca_o <= ca_word_reg;
      end
    end
  end

  // Read words from the user: one in flight per handshake round trip.
  assign rd_accept = rd_valid_i & rd_ready_o;
  always_ff @(posedge ref_clk_i or posedge core_rst) begin
    if (core_rst) begin
      rd_req_reg <= 1'b0;
      rd_hold_reg <= '0;
      rd_ready_o <= 1'b0;
    end else begin
      rd_ready_o <= !rd_accept && (rd_req_reg == ack_s2_reg);
      if (rd_accept) begin
        rd_hold_reg <= rd_data_i;
        rd_req_reg <= ~rd_req_reg;
      end
    end
  end

  // Write words wait in one slot until the FIFO takes them. The host cannot
  // be stalled, so a word arriving on a full slot the FIFO cannot take is counted as an overrun.
  assign wr_new = wr_s2_reg ^ wr_s3_reg;
  assign overrun_evt = wr_new && pend_reg && !fifo_in.ready;
  always_ff @(posedge ref_clk_i or posedge core_rst) begin
    if (core_rst) begin
      pend_reg <= 1'b0;
      pend_data_reg <= '0;
    end else if (wr_new) begin
      pend_reg <= 1'b1;
      pend_data_reg <= wr_word_reg;
    end else if (fifo_in.ready) begin
      pend_reg <= 1'b0;
    end
  end

  assign fifo_in.valid = pend_reg;
  assign fifo_in.data = pend_data_reg;

  hfd_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(WR_DEPTH)
  ) u_wr_fifo (
    .clk_i(ref_clk_i),
    .rst_i(core_rst),
    .in_s(fifo_in),
    .out_s(fifo_out)
  );

  assign wr_data_o = fifo_out.data;
  assign wr_valid_o = fifo_out.valid;
  assign fifo_out.ready = wr_ready_i;

  // Sticky interrupt and overrun flags; a new event wins over a clear.
  always_ff @(posedge ref_clk_i or posedge core_rst) begin
    if (core_rst) begin
      int_flag_reg <= 1'b0;
      overrun_o <= 1'b0;
    end else begin
      if (event_i || overrun_evt) begin
        int_flag_reg <= 1'b1;
      end else if (int_clear_i) begin
        int_flag_reg <= 1'b0;
      end
      if (overrun_evt) begin
        overrun_o <= 1'b1;
      end else if (int_clear_i) begin
        overrun_o <= 1'b0;
      end
    end
  end
endmodule

// >>> sim/hfd_pin_props.sv
/*
  Checker for the flash bus pin block, watching the top module's ports.
  Assumes all watched signals are sampled on the reference clock.
*/
`timescale 1ns/1ps
module hfd_pin_props
  import hfd_pkg::*;
#(
  parameter int POR_CYCLES = 10
) (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Pins.
  input wire logic cs_n_i,
  input wire logic reset_n_i,
  input wire logic dq_oe_o,
  input wire logic read_strobe_oe_o,
  input wire logic int_n_o,
  input wire logic int_n_oe_o,
  input wire logic por_out_n_o,
  input wire logic por_out_n_oe_o,
  // User side.
  input wire logic [hfd_pkg::EXT_W-1:0] por_ext_i,
  input wire logic event_i,
  input wire logic [hfd_pkg::CA_W-1:0] ca_o,
  input wire logic ca_valid_o,
  input wire hfd_pkg::hfd_dev_e dev_state_o
);
  int unsigned cyc;

  // Edges since power-on reset ended; saturates so the window never wraps.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cyc <= 0;
    end else if (cyc < 32'h0000ffff) begin
      cyc <= cyc + 1;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  property p_int_low; int_n_o == 1'b0; endproperty
  a_int_low: assert property (p_int_low) else $error("interrupt pin high");
  property p_int_set; event_i |-> ##[1:2] int_n_oe_o; endproperty
  a_int_set: assert property (p_int_set) else $error("event not flagged");
  property p_por_low; por_out_n_o == 1'b0; endproperty
  a_por_low: assert property (p_por_low) else $error("reset pin high");
  property p_por_hold; (cyc + 1 < POR_CYCLES + por_ext_i) |-> por_out_n_oe_o; endproperty
  a_por_hold: assert property (p_por_hold) else $error("reset out early");
  property p_por_rel; (cyc == POR_CYCLES + por_ext_i + 4) |-> !por_out_n_oe_o; endproperty
  a_por_rel: assert property (p_por_rel) else $error("reset out late");
  property p_standby; $fell(por_out_n_oe_o) |-> ##[0:1] dev_state_o == DV_STANDBY; endproperty
  a_standby: assert property (p_standby) else $error("no standby");
  property p_cs_idle; cs_n_i |-> !dq_oe_o && !read_strobe_oe_o; endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("driving with cs high");
  property p_hw_z; !reset_n_i [*5] |-> !dq_oe_o && !read_strobe_oe_o; endproperty
  a_hw_z: assert property (p_hw_z) else $error("driving in hw reset");
  property p_hw_state; !reset_n_i [*7] |-> dev_state_o == DV_HWRST; endproperty
  a_hw_state: assert property (p_hw_state) else $error("state not hw reset");
  property p_array; $rose(reset_n_i) |-> ##[1:8] dev_state_o == DV_ARRAY_RD; endproperty
  a_array: assert property (p_array) else $error("no array read state");
  property p_wr_dir; ca_valid_o && !ca_o[CA_RW_BIT] |-> !dq_oe_o [*4]; endproperty
  a_wr_dir: assert property (p_wr_dir) else $error("drives on write");
  property p_ca_pulse; ca_valid_o |=> !ca_valid_o; endproperty
  a_ca_pulse: assert property (p_ca_pulse) else $error("ca valid stuck");
endmodule

bind hfd_pin_top hfd_pin_props #(.POR_CYCLES(POR_CYCLES)) i_hfd_pin_props (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .reset_n_i(reset_n_i),
  .dq_oe_o(dq_oe_o), .read_strobe_oe_o(read_strobe_oe_o), .int_n_o(int_n_o),
  .int_n_oe_o(int_n_oe_o), .por_out_n_o(por_out_n_o), .por_out_n_oe_o(por_out_n_oe_o),
  .por_ext_i(por_ext_i), .event_i(event_i), .ca_o(ca_o), .ca_valid_o(ca_valid_o),
  .dev_state_o(dev_state_o)
);

// >>> sim/hfd_host_model.sv
/*
  Host controller model: drives chip select, link clock, skew clock, data.
  Assumes an 80 ns link period; the clock stands still between frames.
*/
`timescale 1ns/1ps
module hfd_host_model
  import hfd_pkg::*;
(
  // Link pins toward the device.
  output logic ck_o,
  output logic skew_o,
  output logic cs_n_o,
  output logic [hfd_pkg::BYTE_W-1:0] dq_bus_o,
  // Device pin outputs.
  input wire logic [hfd_pkg::BYTE_W-1:0] dq_i,
  input wire logic dq_oe_i,
  input wire logic strobe_i
);
  logic [BYTE_W-1:0] hdq;
  logic [WORD_W-1:0] got_w;
  logic got_se, got_h, got_v;

  // Resolved bus; a released host leaves a toggled value, never the last one.
  assign dq_bus_o = dq_oe_i ? dq_i : hdq;

  // Skew clock is the link clock a quarter period late, so it also stops.
  always @(ck_o) skew_o <= #20 ck_o;

  initial begin
    ck_o = 1'b0; // Single-ended clock; the inverted clock input is left open.
    skew_o = 1'b0;
    cs_n_o = 1'b1;
    hdq = 8'h5a;
  end

  // One frame: nw host words, then nclk idle or read clocks.
  task automatic frame(input logic [CA_W-1:0] ca, input logic [WORD_W-1:0] w,
                       input int nw, input int nclk);
    logic [WORD_W-1:0] ws [4];
    ws = '{ca[47:32], ca[31:16], ca[15:0], w};
    got_h = 1'b0;
    got_v = 1'b0;
    cs_n_o = 1'b0;
    for (int i = 0; i < nw + nclk; i++) begin
      hdq = (i < nw) ? ws[i][15:8] : ~hdq;
      #20 ck_o = 1'b1;
      #10 if (dq_oe_i && !got_h) got_se = strobe_i;
      #10 if (dq_oe_i && !got_h) got_w[15:8] = dq_bus_o;
      got_h = got_h | dq_oe_i;
      hdq = (i < nw) ? ws[i][7:0] : ~hdq;
      #20 ck_o = 1'b0;
      #20 if (got_h && !got_v) got_w[7:0] = dq_bus_o;
      got_v = got_h;
    end
    hdq = ~hdq;
    cs_n_o = 1'b1;
    #80;
  endtask
endmodule

// >>> sim/hfd_pin_top_test.sv
/*
  Self-checking bench for the flash bus pin block.
  Assumes a 25 MHz reference clock and the host model on the link side.
*/
`timescale 1ns/1ps
module hfd_pin_top_test;
  import hfd_pkg::*;
  localparam int POR_LIM = 10 + 20;
  localparam logic [CA_W-1:0] CA_WR = 48'h2000_0012_3007;
  localparam logic [CA_W-1:0] CA_RD = 48'ha000_0004_5003;
  logic ref_clk, rst, skew_en, ev, int_clr, rd_valid, wr_ready, pin_low;
  logic [LAT_W-1:0] lat;
  logic [EXT_W-1:0] por_ext;
  logic [WORD_W-1:0] rd_data, wr_data;
  logic [BYTE_W-1:0] dq_o, dq_bus;
  logic [CA_W-1:0] ca;
  logic ck, skew, cs_n, dq_oe, strobe, strobe_oe, int_n, int_oe, por_n, por_oe;
  logic ca_valid, rd_ready, wr_valid, overrun;
  hfd_dev_e dev_state;
  tri1 reset_n_w;
  int fail_count, n_checks;

  // Pin with pull-up: unconnected reads high.
  assign reset_n_w = pin_low ? 1'b0 : 1'bz;

  hfd_pin_top #(.POR_TIME_NS(400)) i_hfd_pin_top (
    .ref_clk_i(ref_clk), .rst_i(rst), .ck_i(ck), .skew_clock_i(skew), .cs_n_i(cs_n),
    .dq_i(dq_bus), .dq_o(dq_o), .dq_oe_o(dq_oe), .read_strobe_o(strobe),
    .read_strobe_oe_o(strobe_oe), .reset_n_i(reset_n_w), .int_n_o(int_n),
    .int_n_oe_o(int_oe), .por_out_n_o(por_n), .por_out_n_oe_o(por_oe),
    .skew_en_i(skew_en), .latency_i(lat), .por_ext_i(por_ext), .event_i(ev),
    .int_clear_i(int_clr), .ca_o(ca), .ca_valid_o(ca_valid), .rd_data_i(rd_data),
    .rd_valid_i(rd_valid), .rd_ready_o(rd_ready), .wr_data_o(wr_data),
    .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .dev_state_o(dev_state),
    .overrun_o(overrun)
  );

  hfd_host_model i_hfd_host_model (
    .ck_o(ck), .skew_o(skew), .cs_n_o(cs_n), .dq_bus_o(dq_bus),
    .dq_i(dq_o), .dq_oe_i(dq_oe), .strobe_i(strobe)
  );

  // Reference clock.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic expect_ca(input logic [CA_W-1:0] exp);
    int k;
    k = 0;
    while (ca_valid !== 1'b1 && k < 80) begin
      step(1);
      k++;
    end
    chk("ca_valid", 1, ca_valid);
    chk("ca_o", exp, ca);
  endtask

  task automatic t_por;
    int n;
    n = 0;
    chk("reset out pulled", 2'b01, {por_n, por_oe});
    while (por_oe === 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    chk("reset out span", 1, n >= POR_LIM && n <= POR_LIM + 2);
    step(1);
    chk("standby", DV_STANDBY, dev_state);
  endtask

  task automatic t_write(input logic [WORD_W-1:0] w);
    fork
      i_hfd_host_model.frame(CA_WR, w, 4, 0);
      expect_ca(CA_WR);
    join
    step(8);
    chk("write word", {1'b1, w}, {wr_valid, wr_data});
    wr_ready = 1'b1;
    step(1);
    wr_ready = 1'b0;
    chk("fifo empty", 0, wr_valid);
  endtask

  // Read with the strobe timed from the link clock or from the skew clock.
  task automatic t_read(input logic sk, input logic [WORD_W-1:0] w);
    int k;
    skew_en = sk;
    fork
      i_hfd_host_model.frame(CA_RD, 16'h0000, 3, 12);
      begin
        expect_ca(CA_RD);
        rd_data = w;
        rd_valid = 1'b1;
        k = 0;
        while (rd_ready !== 1'b1 && k < 40) begin
          step(1);
          k++;
        end
        step(1);
        rd_valid = 1'b0;
      end
    join
    chk("read word", {1'b1, w}, {i_hfd_host_model.got_v, i_hfd_host_model.got_w});
    chk("early strobe", !sk, i_hfd_host_model.got_se);
  endtask

  // Fill the buffer with the reader stalled, then drain it in order.
  task automatic t_fifo;
    int n;
    for (int i = 0; i < 40; i++) i_hfd_host_model.frame(CA_WR, 16'ha500 + i[15:0], 4, 0);
    step(8);
    chk("overrun", 3'b110, {overrun, int_oe, int_n});
    n = 0;
    wr_ready = 1'b1;
    // The 32 buffered words come out in order, then the slot's word: a late
    // arrival overwrites the held one, so the last frame's word survives.
    while (wr_valid === 1'b1 && n < 40) begin
      chk("drained word", 16'ha500 + ((n < FIFO_DEPTH) ? n[15:0] : 16'd39), wr_data);
      step(1);
      n++;
    end
    wr_ready = 1'b0;
    chk("fifo depth", 1, n == FIFO_DEPTH + 1);
    int_clr = 1'b1;
    step(1);
    int_clr = 1'b0;
    step(1);
    chk("int cleared", 2'b00, {overrun, int_oe});
    ev = 1'b1;
    step(1);
    ev = 1'b0;
    step(1);
    chk("int on event", 2'b10, {int_oe, int_n});
  endtask

  // Hardware reset in the middle of a read's latency.
  task automatic t_hwrst;
    int k;
    fork
      i_hfd_host_model.frame(CA_RD, 16'h0000, 3, 12);
      begin
        step(14);
        pin_low = 1'b1;
        step(10);
        chk("z in reset", 2'b00, {dq_oe, strobe_oe});
        chk("state in reset", DV_HWRST, dev_state);
      end
    join
    pin_low = 1'b0;
    k = 0;
    while (dev_state !== DV_ARRAY_RD && k < 10) begin
      step(1);
      k++;
    end
    chk("array read", DV_ARRAY_RD, dev_state);
    step(4);
  endtask

  task automatic report_and_stop;
    $display("checks %0d, errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Whole run is some 25 us; eight times that means a hang.
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    {rst, skew_en, ev, int_clr, rd_valid, wr_ready, pin_low} = 7'h40;
    {lat, por_ext, rd_data, fail_count, n_checks} = '0;
    lat = 4'h8;
    por_ext = 16'h0014;
    step(12);
    rst = 1'b0;
    t_por();
    t_write(16'hc3a5);
    t_read(1'b0, 16'h9e17);
    t_read(1'b1, 16'h4b2d);
    t_fifo();
    t_hwrst();
    t_write(16'h0ff0);
    report_and_stop();
  end
endmodule
